// >>> verilog/dsf_slave.sv
// Slave end: diagnostic area builder and response framer
//
// Contract
// - Pending diagnostics flag data exchange reply high.
// - Master asks diagnostics right after high priority.
// - Any master gets six standard bytes plus area.
// - Static flag keeps exchange state; master polls diagnostics.
// - Present flag set means at least one entry.
// - Flag clear means user bytes are status.
// - Header: type in bits 7-6, length below.
// - Device block type 00, free payload.
// - Identifier block type 01, bit field follows.
// - Channel entry three bytes with id header.
// - Error type codes passed through unchanged.
// - Overflow flag when data exceeds the area.
// - Application publishes only on error change.
`timescale 1ns/10ps
module dsf_slave
	import dsf_pkg::*;
(
	input  wire logic              mclk_i,
	input  wire logic              rst_i,
	dsf_link_if.slave              link,
	input  wire logic              stat_diag_i,
	input  wire logic              user_diag_present_flag_i,
	input  wire logic              ub_clear_i,
	input  wire logic              ub_start_i,
	input  wire logic [1:0]        ub_type_i,
	input  wire logic [4:0]        ub_id_i,
	input  wire logic              ub_byte_valid_i,
	input  wire logic [7:0]        ub_byte_i,
	input  wire logic              ub_end_i,
	input  wire logic              ub_publish_i,
	output logic                   diag_pending_o,
	output logic                   diag_area_overflow_flag_o,
	output logic [PTR_W-1:0]       user_len_o,
	output logic                   busy_o
);

	function automatic logic [7:0] make_hdr(input logic [1:0] typ, input logic [4:0] id,
	                                         input logic [PTR_W-1:0] len);
		logic [7:0] h;
		h = {typ, len};
		if (typ == BT_CHANNEL)
			h = {BT_CHANNEL, 1'b0, id};
		return h;
	endfunction : make_hdr

	logic [7:0]        area_q [AREA_MAX];
	logic [PTR_W-1:0]  commit_q;
	logic [PTR_W-1:0]  hdr_pos_q;
	logic [PTR_W-1:0]  wptr_q;
	logic              bld_q;
	logic              bld_ovf_q;
	logic [1:0]        bld_type_q;
	logic [4:0]        bld_id_q;
	logic              ovf_q;
	logic              pend_q;
	dsf_sstate_t       state_q;
	logic              kind_q;
	logic [PTR_W-1:0]  idx_q;
	logic [PTR_W-1:0]  len_q;
	logic              rsp_valid_q;
	logic [7:0]        rsp_byte_q;
	logic              rsp_last_q;
	logic              rsp_hi_q;

	logic [PTR_W-1:0]  blk_len;
	logic              len_ok;
	logic              close_ok;
	logic              close_drop;
	logic              force_min;
	logic [PTR_W-1:0]  ulen;
	logic              accept;
	logic [7:0]        next_byte;
	logic [PTR_W-1:0]  area_idx;

	assign blk_len    = wptr_q - hdr_pos_q;
	assign len_ok     = (bld_type_q != BT_CHANNEL) || (blk_len == CHAN_LEN);
	assign close_ok   = ub_end_i && bld_q && !bld_ovf_q && len_ok;
	assign close_drop = ub_end_i && bld_q && bld_ovf_q;
	assign force_min  = user_diag_present_flag_i && (commit_q == '0);
	assign ulen       = force_min ? PTR_ONE : commit_q;
	assign accept     = link.req_valid && (state_q == S_IDLE);
	assign area_idx   = idx_q - STD_LEN;

	// Byte at the current index of a diagnostic reply
	always_comb
	begin
		next_byte = 8'h00;
		unique case (idx_q)
			6'h00: next_byte[ST0_EXT_BIT] = user_diag_present_flag_i;
			6'h01: next_byte[ST1_STAT_BIT] = stat_diag_i;
			6'h02: next_byte[ST2_OVF_BIT] = ovf_q;
			6'h03: next_byte = {1'b0, ASSIGNED_MST};
			6'h04: next_byte = IDENT_HI;
			6'h05: next_byte = IDENT_LO;
			default:
				next_byte = force_min ? MIN_BLOCK : area_q[area_idx[4:0]];
		endcase
	end

	// Area storage; payload bytes kept verbatim
	always_ff @(posedge mclk_i)
	begin
		if (ub_byte_valid_i && bld_q && !ub_end_i && (wptr_q != AREA_END))
			area_q[wptr_q[4:0]] <= ub_byte_i;
		else if (close_ok)
			area_q[hdr_pos_q[4:0]] <= make_hdr(bld_type_q, bld_id_q, blk_len);
	end

	// Block under construction
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			bld_q      <= 1'b0;
			bld_ovf_q  <= 1'b0;
			bld_type_q <= BT_DEVICE;
			bld_id_q   <= '0;
			hdr_pos_q  <= '0;
			wptr_q     <= '0;
		end
		else if (ub_clear_i || ub_end_i)
			bld_q <= 1'b0;
		else if (ub_start_i)
		begin
			bld_q      <= 1'b1;
			bld_type_q <= ub_type_i;
			bld_id_q   <= ub_id_i;
			hdr_pos_q  <= commit_q;
			bld_ovf_q  <= (commit_q == AREA_END);
			wptr_q     <= (commit_q == AREA_END) ? commit_q : commit_q + PTR_ONE;
		end
		else if (ub_byte_valid_i && bld_q)
		begin
			if (wptr_q == AREA_END)
				bld_ovf_q <= 1'b1;
			else
				wptr_q <= wptr_q + PTR_ONE;
		end
	end

	// Committed length grows only by whole blocks
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			commit_q <= '0;
		else if (ub_clear_i)
			commit_q <= '0;
		else if (close_ok)
			commit_q <= wptr_q;
	end

	// Overflow flag, set wins over clear
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			ovf_q <= 1'b0;
		else if (close_drop)
			ovf_q <= 1'b1;
		else if (ub_clear_i)
			ovf_q <= 1'b0;
	end

	// New diagnostics pending until a diagnostic reply completes
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			pend_q <= 1'b0;
		else if (ub_publish_i)
			pend_q <= 1'b1;
		else if (state_q == S_SEND && rsp_last_q && kind_q == RQ_DIAG)
			pend_q <= 1'b0;
	end

	// Reply framer
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_q     <= S_IDLE;
			kind_q      <= RQ_DX;
			idx_q       <= '0;
			len_q       <= '0;
			rsp_valid_q <= 1'b0;
			rsp_byte_q  <= 8'h00;
			rsp_last_q  <= 1'b0;
			rsp_hi_q    <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				S_IDLE:
				begin
					idx_q <= '0;
					if (accept)
					begin
						state_q     <= S_SEND;
						kind_q      <= link.req_kind;
						rsp_valid_q <= 1'b1;
						if (link.req_kind == RQ_DIAG)
						begin
							len_q      <= STD_LEN + ulen;
							rsp_byte_q <= next_byte;
							rsp_last_q <= 1'b0;
							rsp_hi_q   <= 1'b0;
							idx_q      <= PTR_ONE;
						end
						else
						begin
							len_q      <= PTR_ONE;
							rsp_byte_q <= DX_ACK;
							rsp_last_q <= 1'b1;
							rsp_hi_q   <= pend_q;
						end
					end
				end
				S_SEND:
				begin
					if (rsp_last_q)
					begin
						state_q     <= S_IDLE;
						rsp_valid_q <= 1'b0;
						rsp_last_q  <= 1'b0;
						rsp_hi_q    <= 1'b0;
					end
					else
					begin
						rsp_byte_q <= next_byte;
						rsp_last_q <= (idx_q == len_q - PTR_ONE);
						idx_q      <= idx_q + PTR_ONE;
					end
				end
			endcase
		end
	end

	assign link.rsp_valid         = rsp_valid_q;
	assign link.rsp_byte          = rsp_byte_q;
	assign link.rsp_last          = rsp_last_q;
	assign link.rsp_hi_prio       = rsp_hi_q;
	assign diag_pending_o         = pend_q;
	assign diag_area_overflow_flag_o = ovf_q;
	assign user_len_o             = commit_q;
	assign busy_o                 = (state_q == S_SEND);

endmodule : dsf_slave

// >>> common/dsf_pkg.sv
// Shared constants and types for the diagnostic formatter ends
package dsf_pkg;

	// User-specific diagnostic area
	localparam int          AREA_MAX    = 32;
	localparam int          PTR_W       = 6;
	localparam logic [5:0]  AREA_END    = 6'h20;
	localparam logic [5:0]  STD_LEN     = 6'h06;
	localparam logic [5:0]  CHAN_LEN    = 6'h03;
	localparam logic [5:0]  PTR_ONE     = 6'h01;

	// Block header layout
	localparam int          HDR_TYPE_LO = 6;
	localparam int          HDR_LEN_W   = 6;
	localparam int          CHAN_ID_W   = 5;
	localparam logic [1:0]  BT_DEVICE   = 2'h0;
	localparam logic [1:0]  BT_IDENT    = 2'h1;
	localparam logic [1:0]  BT_CHANNEL  = 2'h2;
	localparam logic [7:0]  MIN_BLOCK   = 8'h01;

	// Standard part field positions
	localparam int          ST0_EXT_BIT  = 3;
	localparam int          ST1_STAT_BIT = 1;
	localparam int          ST2_OVF_BIT  = 7;
	localparam logic [7:0]  DX_ACK       = 8'h00;
	// Identification bytes: arbitrary values
	localparam logic [7:0]  IDENT_HI     = 8'h5a;
	localparam logic [7:0]  IDENT_LO     = 8'ha5;
	localparam logic [6:0]  ASSIGNED_MST = 7'h01;

	// Request kinds
	localparam logic        RQ_DX        = 1'b0;
	localparam logic        RQ_DIAG      = 1'b1;

	typedef enum logic {
		S_IDLE = 1'b0,
		S_SEND = 1'b1
	} dsf_sstate_t;

	typedef enum logic {
		M_IDLE = 1'b0,
		M_WAIT = 1'b1
	} dsf_mstate_t;

endpackage : dsf_pkg

// >>> common/dsf_link_if.sv
// Link between the polling master end and the diagnosing slave end
`timescale 1ns/10ps
interface dsf_link_if;
	logic       req_valid;
	logic       req_kind;
	logic [6:0] req_master_addr;
	logic       rsp_valid;
	logic [7:0] rsp_byte;
	logic       rsp_last;
	logic       rsp_hi_prio;

	modport slave  (input req_valid, req_kind, req_master_addr,
	                output rsp_valid, rsp_byte, rsp_last, rsp_hi_prio);
	modport master (output req_valid, req_kind, req_master_addr,
	                input rsp_valid, rsp_byte, rsp_last, rsp_hi_prio);
endinterface : dsf_link_if

// >>> verilog/dsf_master.sv
// Master end: polls the slave, follows up with diagnostic requests
`timescale 1ns/10ps
module dsf_master
	import dsf_pkg::*;
#(
	parameter logic [6:0] MY_ADDR = 7'h02
)
(
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	dsf_link_if.master       link,
	input  wire logic        poll_i,
	output logic             busy_o,
	output logic             cycle_was_diag_o,
	output logic             byte_valid_o,
	output logic [7:0]       byte_o,
	output logic             user_byte_o,
	output logic             status_only_o,
	output logic             stat_diag_seen_o,
	output logic             diag_due_o,
	output logic             done_o
);

	dsf_mstate_t       state_q;
	logic              req_valid_q;
	logic              kind_q;
	logic              due_q;
	logic              stat_q;
	logic              ext_q;
	logic [PTR_W-1:0]  idx_q;
	logic              byte_valid_q;
	logic [7:0]        byte_q;
	logic              user_q;
	logic              done_q;
	logic              rx_diag;

	assign rx_diag = link.rsp_valid && (state_q == M_WAIT) && (kind_q == RQ_DIAG);

	// Poll sequencing
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_q     <= M_IDLE;
			req_valid_q <= 1'b0;
			kind_q      <= RQ_DX;
			done_q      <= 1'b0;
		end
		else
		begin
			req_valid_q <= 1'b0;
			done_q      <= 1'b0;
			unique case (state_q)
				M_IDLE:
					if (poll_i)
					begin
						state_q     <= M_WAIT;
						req_valid_q <= 1'b1;
						kind_q      <= (due_q || stat_q) ? RQ_DIAG : RQ_DX;
					end
				M_WAIT:
					if (link.rsp_valid && link.rsp_last)
					begin
						state_q <= M_IDLE;
						done_q  <= 1'b1;
					end
			endcase
		end
	end

	// Follow-up and static flags from replies
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			due_q  <= 1'b0;
			stat_q <= 1'b0;
			ext_q  <= 1'b0;
		end
		else if (state_q == M_WAIT && link.rsp_valid)
		begin
			if (kind_q == RQ_DX && link.rsp_hi_prio)
				due_q <= 1'b1;
			else if (rx_diag && link.rsp_last)
				due_q <= 1'b0;
			if (rx_diag && idx_q == '0)
				ext_q <= link.rsp_byte[ST0_EXT_BIT];
			if (rx_diag && idx_q == PTR_ONE)
				stat_q <= link.rsp_byte[ST1_STAT_BIT];
		end
	end

	// Received diagnostic bytes to the user
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			idx_q        <= '0;
			byte_valid_q <= 1'b0;
			byte_q       <= 8'h00;
			user_q       <= 1'b0;
		end
		else
		begin
			byte_valid_q <= rx_diag;
			user_q       <= rx_diag && (idx_q >= STD_LEN);
			if (rx_diag)
			begin
				byte_q <= link.rsp_byte;
				idx_q  <= link.rsp_last ? '0 : idx_q + PTR_ONE;
			end
		end
	end

	assign link.req_valid       = req_valid_q;
	assign link.req_kind        = kind_q;
	assign link.req_master_addr = MY_ADDR;
	assign busy_o               = (state_q == M_WAIT);
	assign cycle_was_diag_o     = kind_q;
	assign byte_valid_o         = byte_valid_q;
	assign byte_o               = byte_q;
	assign user_byte_o          = user_q;
	assign status_only_o        = user_q && !ext_q;
	assign stat_diag_seen_o     = stat_q;
	assign diag_due_o           = due_q;
	assign done_o               = done_q;

endmodule : dsf_master

// >>> test/dsf_link_sva.sv
// Link checker for the diagnostic formatter ends
`timescale 1ns/10ps
module dsf_link_sva
	import dsf_pkg::*;
(
	input  wire logic       mclk_i,
	input  wire logic       rst_i,
	input  wire logic       req_valid,
	input  wire logic       req_kind,
	input  wire logic [6:0] req_master_addr,
	input  wire logic       rsp_valid,
	input  wire logic [7:0] rsp_byte,
	input  wire logic       rsp_last,
	input  wire logic       rsp_hi_prio
);
	logic [5:0] idx_q;
	logic       kind_q;
	logic       stat_q;
	logic       due_q;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	// Byte index within a reply
	always_ff @(posedge mclk_i or posedge rst_i)
		if (rst_i)
			idx_q <= '0;
		else
			idx_q <= rsp_valid ? idx_q + PTR_ONE : '0;

	always_ff @(posedge mclk_i or posedge rst_i)
		if (rst_i)
			kind_q <= 1'b0;
		else if (req_valid)
			kind_q <= req_kind;

	// Last static bit seen in a diagnostic reply
	always_ff @(posedge mclk_i or posedge rst_i)
		if (rst_i)
			stat_q <= 1'b0;
		else if (rsp_valid && kind_q && idx_q == 6'h01)
			stat_q <= rsp_byte[ST1_STAT_BIT];

	always_ff @(posedge mclk_i or posedge rst_i)
		if (rst_i)
			due_q <= 1'b0;
		else if (rsp_hi_prio)
			due_q <= 1'b1;
		else if (req_valid)
			due_q <= 1'b0;

	AST_REQ_ANSWERED: assert property (req_valid |=> rsp_valid)
		else $error("request not answered");
	AST_DX_SINGLE: assert property (req_valid && req_kind == RQ_DX |=> rsp_last && rsp_byte == DX_ACK)
		else $error("exchange reply wrong");
	AST_HIPRIO_DX: assert property (rsp_hi_prio |-> rsp_valid && rsp_last && !kind_q)
		else $error("priority outside exchange reply");
	AST_DIAG_FOLLOWS: assert property (req_valid && due_q |-> req_kind == RQ_DIAG)
		else $error("no diagnostic request after priority reply");
	AST_STD_SIX: assert property (req_valid && req_kind == RQ_DIAG
		|=> (rsp_valid && !rsp_last) [*5] ##1 rsp_valid)
		else $error("standard part short");
	AST_STD_IDENT: assert property (req_valid && req_kind == RQ_DIAG |-> ##4 rsp_byte == ASSIGNED_MST
		##1 rsp_byte == IDENT_HI ##1 rsp_byte == IDENT_LO)
		else $error("standard bytes 3 to 5 wrong");
	AST_LAST_ENDS: assert property (rsp_last |=> !rsp_valid)
		else $error("reply runs past last");
	AST_EXT_ENTRY: assert property (rsp_valid && kind_q && idx_q == 6'h00 && rsp_byte[ST0_EXT_BIT]
		|-> !rsp_last [*6])
		else $error("present flag without entry");
	AST_STAT_POLL: assert property (req_valid && stat_q |-> req_kind == RQ_DIAG)
		else $error("exchange during static diagnostics");
	AST_HDR_LEN: assert property (rsp_valid && kind_q && idx_q == 6'h06
		&& rsp_byte[7:6] != BT_CHANNEL |-> rsp_byte[5:0] != 6'h00)
		else $error("block header without length");
	AST_ANY_MASTER: assert property (req_valid && req_kind == RQ_DIAG
		&& req_master_addr != ASSIGNED_MST |=> rsp_valid ##3 rsp_byte == {1'b0, ASSIGNED_MST})
		else $error("foreign master request not served");
endmodule : dsf_link_sva

// >>> test/dp_slave_diag_formatter_bench.sv
// Self-checking bench for the two formatter ends
`timescale 1ns/10ps
module dp_slave_diag_formatter_bench
	import dsf_pkg::*;
;
	typedef struct packed {
		logic [1:0] t;
		logic [4:0] id;
		logic [3:0] n;
		logic       f;
		logic [3:0] en;
		logic [7:0] hdr;
	} dsf_row_t;

	logic       mclk_i = 1'b0;
	logic       rst_i = 1'b1;
	logic       poll_i = 1'b0;
	logic       stat_i = 1'b0;
	logic       flag_i = 1'b0;
	logic       clr = 1'b0;
	logic       start = 1'b0;
	logic       bv = 1'b0;
	logic       bend = 1'b0;
	logic       pub = 1'b0;
	logic [1:0] typ = 2'h0;
	logic [4:0] id = 5'h00;
	logic [7:0] bb = 8'h00;
	logic       s_pend, s_ovf, s_busy, m_busy, m_diag, m_bv, m_user, m_so, m_ss, m_due, m_done;
	logic [5:0] s_len;
	logic [7:0] m_byte;
	logic [7:0] got [0:39];
	logic       so;
	logic       uf;
	int         ngot;
	int         error_cnt = 0;
	int         num_checks = 0;
	dsf_row_t   rows [0:3];

	always #50 mclk_i = ~mclk_i;

	dsf_link_if link();
	dsf_slave u_dsf_slave (.mclk_i(mclk_i), .rst_i(rst_i), .link(link), .stat_diag_i(stat_i),
		.user_diag_present_flag_i(flag_i), .ub_clear_i(clr), .ub_start_i(start), .ub_type_i(typ),
		.ub_id_i(id), .ub_byte_valid_i(bv), .ub_byte_i(bb), .ub_end_i(bend), .ub_publish_i(pub),
		.diag_pending_o(s_pend), .diag_area_overflow_flag_o(s_ovf), .user_len_o(s_len),
		.busy_o(s_busy));
	// Foreign master address, not the assigned one
	dsf_master #(.MY_ADDR(7'h09)) u_dsf_master (.mclk_i(mclk_i), .rst_i(rst_i), .link(link),
		.poll_i(poll_i), .busy_o(m_busy), .cycle_was_diag_o(m_diag), .byte_valid_o(m_bv),
		.byte_o(m_byte), .user_byte_o(m_user), .status_only_o(m_so), .stat_diag_seen_o(m_ss),
		.diag_due_o(m_due), .done_o(m_done));
	dsf_link_sva u_dsf_link_sva (.mclk_i(mclk_i), .rst_i(rst_i), .req_valid(link.req_valid),
		.req_kind(link.req_kind), .req_master_addr(link.req_master_addr),
		.rsp_valid(link.rsp_valid), .rsp_byte(link.rsp_byte), .rsp_last(link.rsp_last),
		.rsp_hi_prio(link.rsp_hi_prio));

	task summarize;
		if (error_cnt == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize

	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task tick;
		@(posedge mclk_i);
		#1;
	endtask : tick

	task build(input logic [1:0] t, input logic [4:0] i, input int n);
		int k;
		typ = t;
		id = i;
		start = 1'b1;
		tick;
		start = 1'b0;
		for (k = 0; k < n; k++)
		begin
			bv = 1'b1;
			bb = 8'ha0 + k[7:0];
			tick;
		end
		bv = 1'b0;
		bend = 1'b1;
		tick;
		bend = 1'b0;
		tick;
	endtask : build

	task poll;
		int w;
		ngot = 0;
		so = 1'b0;
		uf = 1'b0;
		for (w = 0; w < 20 && m_busy !== 1'b0; w++)
			tick;
		poll_i = 1'b1;
		tick;
		poll_i = 1'b0;
		for (w = 0; w < 80; w++)
		begin
			if (m_bv === 1'b1 && ngot < 40)
			begin
				got[ngot] = m_byte;
				if (ngot == 6)
				begin
					so = m_so;
					uf = m_user;
				end
				ngot++;
			end
			if (m_done === 1'b1)
				break;
			tick;
		end
		check("done", m_done, 1'b1);
		check("slave idle", s_busy, 1'b0);
		tick;
	endtask : poll

	task publish;
		pub = 1'b1; // One publish per change of diagnostics
		tick;
		pub = 1'b0;
	endtask : publish

	task clear;
		clr = 1'b1;
		tick;
		clr = 1'b0;
	endtask : clear

	initial
	begin
		#2_000_000;
		error_cnt++;
		summarize;
	end

	initial
	begin
		rows[0] = '{BT_DEVICE, 5'h00, 4'h2, 1'b1, 4'h3, 8'h03};
		rows[1] = '{BT_IDENT, 5'h00, 4'h1, 1'b0, 4'h2, 8'h42};
		rows[2] = '{BT_CHANNEL, 5'h05, 4'h2, 1'b1, 4'h3, 8'h85};
		rows[3] = '{BT_CHANNEL, 5'h03, 4'h1, 1'b1, 4'h1, 8'h01};
		repeat (20) tick;
		rst_i = 1'b0;
		tick;
		check("reset len", s_len, 6'h00);
		check("reset pend", s_pend, 1'b0);
		check("reset ovf", s_ovf, 1'b0);
		for (int r = 0; r < 4; r++)
		begin
			flag_i = rows[r].f;
			clear;
			build(rows[r].t, rows[r].id, rows[r].n);
			check("len", s_len, (rows[r].hdr == 8'h01) ? 0 : rows[r].en);
			publish;
			check("pend", s_pend, 1'b1);
			poll;
			check("dx kind", m_diag, 1'b0);
			check("due", m_due, 1'b1);
			poll;
			check("diag kind", m_diag, 1'b1);
			check("count", ngot, 6 + rows[r].en);
			check("master", got[3], ASSIGNED_MST);
			check("ext", got[0][ST0_EXT_BIT], rows[r].f);
			check("hdr", got[6], rows[r].hdr);
			if (rows[r].en > 1)
				check("payload", got[7], 8'ha0);
			check("status", so, !rows[r].f);
			check("user", uf, 1'b1);
			check("pend clr", s_pend, 1'b0);
		end
		clear;
		stat_i = 1'b1;
		publish;
		poll;
		poll;
		check("stat bit", got[1][ST1_STAT_BIT], 1'b1);
		poll;
		check("stat poll", m_diag, 1'b1);
		check("stat seen", m_ss, 1'b1);
		stat_i = 1'b0;
		poll;
		poll;
		check("resume", m_diag, 1'b0);
		clear;
		build(BT_DEVICE, 5'h00, 20);
		build(BT_DEVICE, 5'h00, 20);
		check("ovf len", s_len, 6'h15);
		check("ovf", s_ovf, 1'b1);
		publish;
		poll;
		poll;
		check("ovf count", ngot, 27);
		check("ovf bit", got[2][ST2_OVF_BIT], 1'b1);
		clear;
		tick;
		check("ovf clr", s_ovf, 1'b0);
		summarize;
	end
endmodule : dp_slave_diag_formatter_bench
